// [hdl/cell_array_pkg.sv]
// constants and types shared by the logic cell array and its bus port
package cell_array_pkg;
  // array geometry
  localparam int NUM_REGS = 20;
  localparam int NUM_CELLS = 10;
  localparam int NUM_INS = 11;
  localparam int ARR_W = 42;
  localparam int SLOTS = 8;
  localparam int MIN_TERMS = 4;
  // product term index map
  localparam int CLK_BASE = 160;
  localparam int RST_BASE = 180;
  localparam int OE_BASE = 200;
  localparam int PRESET_IDX = 210;
  localparam int NUM_TERMS = 211;
  // bus address map (byte addresses)
  localparam int ADDR_W = 16;
  localparam logic [15:0] TERM_END = 16'h0d30;
  localparam logic [15:0] TTYPE_OFS = 16'h1000;
  localparam logic [15:0] CLKSEL_OFS = 16'h1004;
  localparam logic [15:0] SECURE_OFS = 16'h1008;
  localparam logic [15:0] PRELOAD_OFS = 16'h100c;
  localparam logic [15:0] PINS_OFS = 16'h1010;
  localparam logic [15:0] COUNT_OFS = 16'h1040;
  localparam logic [15:0] COUNT_END = 16'h1090;
  // reset and readback values
  localparam logic [3:0] COUNT_RST = 4'h8;
  localparam logic [31:0] ONES_LO = 32'hffff_ffff;
  localparam logic [31:0] ONES_HI = 32'h0000_03ff;
  localparam logic [31:0] ONES_REG = 32'h000f_ffff;
  localparam logic [31:0] ONES_CNT = 32'h0000_000f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {RD_IDLE = 3'b001, RD_FETCH = 3'b010, RD_RESP = 3'b100} rd_state_t;
endpackage

// [hdl/axil_port.sv]
// axi4-lite slave front end for the logic cell array registers
`timescale 1ns/100ps
module axil_port
  import cell_array_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [cell_array_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [cell_array_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic wr_en_out,
  output logic [cell_array_pkg::ADDR_W-1:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic wr_ok_in,
  output logic [cell_array_pkg::ADDR_W-1:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_ok_in
);
  import cell_array_pkg::*;

  logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [ADDR_W-1:0] waddr_ff, nxt_waddr, raddr_ff, nxt_raddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  rd_state_t rd_state_ff, nxt_rd_state;
  logic wr_go;

  // address and data may arrive in either order; the write fires once both are held
  assign wr_go = aw_have_ff & w_have_ff & ~bvalid_ff;
  always_comb
  begin
    nxt_aw_have = aw_have_ff;
    nxt_w_have = w_have_ff;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid_in && awready_ff)
    begin
      nxt_aw_have = 1'b1;
      nxt_waddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_ff)
    begin
      nxt_w_have = 1'b1;
      nxt_wdata = s_axi_wdata_in;
      nxt_wstrb = s_axi_wstrb_in;
    end
    if (bvalid_ff && s_axi_bready_in)
      nxt_bvalid = 1'b0;
    if (wr_go)
    begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = wr_ok_in ? RESP_OKAY : RESP_SLVERR;
    end
    // no new write is taken while a response is still pending
    nxt_awready = ~nxt_aw_have & ~nxt_bvalid;
    nxt_wready = ~nxt_w_have & ~nxt_bvalid;
  end

  // read channel: take address, fetch one cycle, then hold the answer
  always_comb
  begin
    nxt_rd_state = rd_state_ff;
    nxt_raddr = raddr_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_arready = arready_ff;
    case (rd_state_ff)
      RD_IDLE:
        if (s_axi_arvalid_in)
        begin
          nxt_raddr = s_axi_araddr_in;
          nxt_arready = 1'b0;
          nxt_rd_state = RD_FETCH;
        end
      RD_FETCH:
      begin
        nxt_rdata = rd_data_in;
        nxt_rresp = rd_ok_in ? RESP_OKAY : RESP_SLVERR;
        nxt_rvalid = 1'b1;
        nxt_rd_state = RD_RESP;
      end
      RD_RESP:
        if (s_axi_rready_in)
        begin
          nxt_rvalid = 1'b0;
          nxt_arready = 1'b1;
          nxt_rd_state = RD_IDLE;
        end
      default:
      begin
        nxt_rvalid = 1'b0;
        nxt_arready = 1'b1;
        nxt_rd_state = RD_IDLE;
      end
    endcase
  end

  // bus state registers
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      waddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      rd_state_ff <= RD_IDLE;
      raddr_ff <= '0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
    else
    begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      rd_state_ff <= nxt_rd_state;
      raddr_ff <= nxt_raddr;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      rvalid_ff <= nxt_rvalid;
      arready_ff <= nxt_arready;
    end
  end

  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out = wready_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign s_axi_rresp_out = rresp_ff;
  assign wr_en_out = wr_go;
  assign wr_addr_out = waddr_ff;
  assign wr_data_out = wdata_ff;
  assign wr_strb_out = wstrb_ff;
  assign rd_addr_out = raddr_ff;

  // a response stays put until the master takes it
  bresp_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    bvalid_ff && !s_axi_bready_in |=> bvalid_ff && $stable(bresp_ff))
    else $error("write response dropped before bready");
  rdata_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    rvalid_ff && !s_axi_rready_in |=> rvalid_ff && $stable(rdata_ff))
    else $error("read data changed before rready");
  cov_write_c: cover property (@(posedge clk_in) disable iff (reset_in) bvalid_ff && s_axi_bready_in);
  cov_read_c: cover property (@(posedge clk_in) disable iff (reset_in) rvalid_ff && s_axi_rready_in);
endmodule

// [hdl/logic_cell_array.sv]
// register and output logic of a twenty-register programmable logic cell array
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
module logic_cell_array
  import cell_array_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic pin_clk_in,
  input wire logic [cell_array_pkg::NUM_INS-1:0] logic_pins_in,
  input wire logic [cell_array_pkg::NUM_CELLS-1:0] io_pins_in,
  output logic [cell_array_pkg::NUM_CELLS-1:0] io_pins_out,
  output logic [cell_array_pkg::NUM_CELLS-1:0] io_oe_out,
  input wire logic [cell_array_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [cell_array_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  import cell_array_pkg::*;

  // a term with no connected input counts as false, so blank terms stay inactive
  function automatic logic pterm(input logic [ARR_W-1:0] arr, input logic [ARR_W-1:0] t,
                                 input logic [ARR_W-1:0] c);
    pterm = ((t | c) != '0) && ((arr & t) == t) && ((~arr & c) == c);
  endfunction

  // byte-lane merge for a 32-bit register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (st[b])
        r[8*b +: 8] = wd[8*b +: 8];
    merge = r;
  endfunction

  logic wr_en;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic wr_ok, rd_ok;

  axil_port u_port (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .s_axi_awaddr_in(s_axi_awaddr_in),
    .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in),
    .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out),
    .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_ok_in(wr_ok),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_ok_in(rd_ok)
  );

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam int PIN_W = NUM_INS + NUM_CELLS + 1;
  logic [PIN_W-1:0] pin_meta_ff, pin_sync_ff;
  logic pclk;
  logic [NUM_INS-1:0] in_sync;
  logic [NUM_CELLS-1:0] io_sync;
  logic [ARR_W-1:0] arr;
  // declared here because the array input vector feeds it back
  logic [NUM_REGS-1:0] reg_ff;

  // two stages; only the second stage is read by the array
  always_ff @(posedge clk_in)
  begin
    pin_meta_ff <= {io_pins_in, logic_pins_in, pin_clk_in};
    pin_sync_ff <= pin_meta_ff;
  end
  assign pclk = pin_sync_ff[0];
  assign in_sync = pin_sync_ff[NUM_INS:1];
  assign io_sync = pin_sync_ff[PIN_W-1:NUM_INS+1];

  assign arr = {reg_ff, io_sync, in_sync, pclk};

  // ****************************************************************
  // configuration store
  // ****************************************************************
  logic [ARR_W-1:0] term_t_ff [NUM_TERMS];
  logic [ARR_W-1:0] term_c_ff [NUM_TERMS];
  logic [ARR_W-1:0] nxt_term_t [NUM_TERMS];
  logic [ARR_W-1:0] nxt_term_c [NUM_TERMS];
  logic [NUM_REGS-1:0] ttype_ff, nxt_ttype, clksel_ff, nxt_clksel;
  logic [3:0] cnt_ff [NUM_REGS];
  logic [3:0] nxt_cnt [NUM_REGS];
  logic secure_ff, nxt_secure;
  logic term_hit, cnt_hit, preload_we;
  logic [7:0] w_idx;
  logic [4:0] w_cidx;
  logic [31:0] cnt_word;

  assign term_hit = wr_addr < TERM_END;
  assign cnt_hit = (wr_addr >= COUNT_OFS) && (wr_addr < COUNT_END);
  assign w_idx = wr_addr[11:4];
  assign w_cidx = 5'((wr_addr - COUNT_OFS) >> 2);
  assign preload_we = wr_en && (wr_addr == PRELOAD_OFS);
  assign wr_ok = term_hit || cnt_hit || (wr_addr == TTYPE_OFS) || (wr_addr == CLKSEL_OFS)
                 || (wr_addr == SECURE_OFS) || (wr_addr == PRELOAD_OFS);

  // software writes; a term word is 32 low bits or 10 high bits of one mask
  always_comb
  begin
    nxt_term_t = term_t_ff;
    nxt_term_c = term_c_ff;
    nxt_ttype = ttype_ff;
    nxt_clksel = clksel_ff;
    nxt_cnt = cnt_ff;
    nxt_secure = secure_ff;
    cnt_word = 32'h0000_0000;
    if (wr_en && term_hit)
      case (wr_addr[3:2])
        2'd0: nxt_term_t[w_idx][31:0] = merge(term_t_ff[w_idx][31:0], wr_data, wr_strb);
        2'd1: nxt_term_t[w_idx][ARR_W-1:32] = 10'(merge({22'h0, term_t_ff[w_idx][ARR_W-1:32]}, wr_data, wr_strb));
        2'd2: nxt_term_c[w_idx][31:0] = merge(term_c_ff[w_idx][31:0], wr_data, wr_strb);
        default: nxt_term_c[w_idx][ARR_W-1:32] = 10'(merge({22'h0, term_c_ff[w_idx][ARR_W-1:32]}, wr_data, wr_strb));
      endcase
    if (wr_en && wr_addr == TTYPE_OFS)
      nxt_ttype = 20'(merge({12'h0, ttype_ff}, wr_data, wr_strb));
    if (wr_en && wr_addr == CLKSEL_OFS)
      nxt_clksel = 20'(merge({12'h0, clksel_ff}, wr_data, wr_strb));
    if (wr_en && cnt_hit && wr_strb[0])
    begin
      cnt_word = wr_data;
      if (cnt_word > 32'(SLOTS))
        nxt_cnt[w_cidx] = 4'(SLOTS);
      else if (cnt_word < 32'(MIN_TERMS))
        nxt_cnt[w_cidx] = 4'(MIN_TERMS);
      else
        nxt_cnt[w_cidx] = cnt_word[3:0];
    end
    // security only ever sets; cleared by reset alone
    if (wr_en && wr_addr == SECURE_OFS && wr_strb[0] && wr_data[0])
      nxt_secure = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < NUM_TERMS; i++)
      begin
        term_t_ff[i] <= '0;
        term_c_ff[i] <= '0;
      end
      for (int i = 0; i < NUM_REGS; i++)
        cnt_ff[i] <= COUNT_RST;
      ttype_ff <= '0;
      clksel_ff <= '0;
      secure_ff <= 1'b0;
    end
    else
    begin
      term_t_ff <= nxt_term_t;
      term_c_ff <= nxt_term_c;
      cnt_ff <= nxt_cnt;
      ttype_ff <= nxt_ttype;
      clksel_ff <= nxt_clksel;
      secure_ff <= nxt_secure;
    end
  end

  // ****************************************************************
  // register cells
  // ****************************************************************
  logic [NUM_REGS-1:0] nxt_reg, master_ff, nxt_master, clk_prev_ff, nxt_clk_prev;
  logic [NUM_REGS-1:0] sum_vec, lvl_vec, rise_vec, rst_vec, set_vec;
  logic [NUM_CELLS-1:0] oe_ff, nxt_oe;
  logic preset;

  // private sum, clock and reset terms
  // only the first count slots contribute
  always_comb
  begin
    preset = pterm(arr, term_t_ff[PRESET_IDX], term_c_ff[PRESET_IDX]);
    for (int i = 0; i < NUM_REGS; i++)
    begin
      sum_vec[i] = 1'b0;
      for (int k = 0; k < SLOTS; k++)
        if (4'(k) < cnt_ff[i])
          sum_vec[i] = sum_vec[i] | pterm(arr, term_t_ff[i*SLOTS+k], term_c_ff[i*SLOTS+k]);
      lvl_vec[i] = clksel_ff[i] ? pclk : pterm(arr, term_t_ff[CLK_BASE+i], term_c_ff[CLK_BASE+i]);
      rst_vec[i] = pterm(arr, term_t_ff[RST_BASE+i], term_c_ff[RST_BASE+i]);
    end
    for (int j = 0; j < NUM_CELLS; j++)
      nxt_oe[j] = pterm(arr, term_t_ff[OE_BASE+j], term_c_ff[OE_BASE+j]);
  end
  assign rise_vec = lvl_vec & ~clk_prev_ff;
  // preset only lands where the clock rises
  assign set_vec = rise_vec & {NUM_REGS{preset}} & ~rst_vec & {NUM_REGS{~preload_we}};

  // master follows data while its clock is low; slave takes master at the rise
  always_comb
  begin
    nxt_clk_prev = lvl_vec;
    nxt_master = master_ff;
    nxt_reg = reg_ff;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      // toggle type flips on true sum, else holds; data type takes the sum
      if (!lvl_vec[i])
        nxt_master[i] = ttype_ff[i] ? (reg_ff[i] ^ sum_vec[i]) : sum_vec[i];
      if (rise_vec[i])
        nxt_reg[i] = preset ? 1'b1 : master_ff[i];
      if (preload_we && wr_strb[i/8])
      begin
        nxt_reg[i] = wr_data[i];
        nxt_master[i] = wr_data[i];
      end
      if (rst_vec[i])
      begin
        nxt_reg[i] = 1'b0;
        nxt_master[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      reg_ff <= '0;
      master_ff <= '0;
      clk_prev_ff <= '0;
      oe_ff <= '0;
    end
    else
    begin
      reg_ff <= nxt_reg;
      master_ff <= nxt_master;
      clk_prev_ff <= nxt_clk_prev;
      oe_ff <= nxt_oe;
    end
  end

  assign io_pins_out = reg_ff[NUM_CELLS-1:0];
  assign io_oe_out = oe_ff;

  // ****************************************************************
  // read decode
  // ****************************************************************
  logic [7:0] r_idx;
  logic [4:0] r_cidx;
  logic r_term, r_cnt;
  assign r_idx = rd_addr[11:4];
  assign r_cidx = 5'((rd_addr - COUNT_OFS) >> 2);
  assign r_term = rd_addr < TERM_END;
  assign r_cnt = (rd_addr >= COUNT_OFS) && (rd_addr < COUNT_END);

  // secured configuration reads as all programmed
  always_comb
  begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    if (r_term)
      case (rd_addr[3:2])
        2'd0: rd_data = secure_ff ? ONES_LO : term_t_ff[r_idx][31:0];
        2'd1: rd_data = secure_ff ? ONES_HI : {22'h0, term_t_ff[r_idx][ARR_W-1:32]};
        2'd2: rd_data = secure_ff ? ONES_LO : term_c_ff[r_idx][31:0];
        default: rd_data = secure_ff ? ONES_HI : {22'h0, term_c_ff[r_idx][ARR_W-1:32]};
      endcase
    else if (r_cnt)
      rd_data = secure_ff ? ONES_CNT : {28'h0, cnt_ff[r_cidx]};
    else if (rd_addr == TTYPE_OFS)
      rd_data = secure_ff ? ONES_REG : {12'h0, ttype_ff};
    else if (rd_addr == CLKSEL_OFS)
      rd_data = secure_ff ? ONES_REG : {12'h0, clksel_ff};
    else if (rd_addr == SECURE_OFS)
      rd_data = {31'h0, secure_ff};
    else if (rd_addr == PRELOAD_OFS)
      rd_data = {12'h0, reg_ff};
    else if (rd_addr == PINS_OFS)
      rd_data = {10'h0, pin_sync_ff};
    else
      rd_ok = 1'b0;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  reset_clears_a: assert property (@(posedge clk_in) disable iff (reset_in)
    1'b1 |=> (reg_ff & $past(rst_vec)) == '0) else $error("reset term did not clear register");
  master_clears_a: assert property (@(posedge clk_in) disable iff (reset_in)
    1'b1 |=> (master_ff & $past(rst_vec)) == '0) else $error("reset term left master stage set");
  preset_sets_a: assert property (@(posedge clk_in) disable iff (reset_in)
    1'b1 |=> (reg_ff & $past(set_vec)) == $past(set_vec)) else $error("preset did not set register");
  hold_no_edge_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (rise_vec == '0) && (rst_vec == '0) && !preload_we |=> $stable(reg_ff))
    else $error("register changed without clock edge");
  oe_follows_a: assert property (@(posedge clk_in) disable iff (reset_in)
    1'b1 |=> io_oe_out == $past(nxt_oe)) else $error("pin enable does not follow its term");
  secure_read_a: assert property (@(posedge clk_in) disable iff (reset_in)
    secure_ff && r_term && rd_addr[2] == 1'b0 |-> rd_data == ONES_LO) else $error("secured term readable");
  secure_sticky_a: assert property (@(posedge clk_in) disable iff (reset_in)
    secure_ff |=> secure_ff) else $error("security setting lost");
  count_range_a: assert property (@(posedge clk_in) disable iff (reset_in)
    cnt_ff[0] >= 4'(MIN_TERMS) && cnt_ff[0] <= 4'(SLOTS)) else $error("term count out of range");
  powerup_clear_a: assert property (@(posedge clk_in)
    $fell(reset_in) |-> reg_ff == '0 && master_ff == '0) else $error("registers not cleared at reset");
  cov_preset_c: cover property (@(posedge clk_in) disable iff (reset_in) set_vec != '0);
  cov_toggle_c: cover property (@(posedge clk_in) disable iff (reset_in) (rise_vec & ttype_ff) != '0);
  cov_secure_c: cover property (@(posedge clk_in) disable iff (reset_in) secure_ff && r_term);
endmodule

// [tb/board_model.sv]
// board logic that shares the ten bidirectional pins with the device
`timescale 1ns/100ps
module board_model
(
  input wire logic [9:0] oe_in,
  input wire logic [9:0] dev_in,
  input wire logic [9:0] drv_in,
  output logic [9:0] pin_out
);
  // board drives a pin only while the device leaves it free
  assign pin_out = (oe_in & dev_in) | (~oe_in & drv_in);
endmodule

// [tb/tb_top.sv]
// self-checking bench for the logic cell array
`timescale 1ns/100ps
module tb_top;
  import cell_array_pkg::*;
  logic clk_in, reset_in, pclk, awv, wv, bre, arv, rre, awr, wrdy, bv, arr, rv;
  logic [10:0] lp;
  logic [9:0] drv, pins, pout, poe;
  logic [15:0] awa, ara;
  logic [31:0] wd, rdat, v, q;
  logic [1:0] br, rr;
  logic [3:0] ws;
  int fail_count, comparisons, i;
  logic_cell_array dut_u (.clk_in(clk_in), .reset_in(reset_in), .pin_clk_in(pclk), .logic_pins_in(lp),
    .io_pins_in(pins), .io_pins_out(pout), .io_oe_out(poe), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre));
  board_model board_u (.oe_in(poe), .dev_in(pout), .drv_in(drv), .pin_out(pins));
  // ****************
  // bench tasks
  // ****************
  task automatic conclude;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask
  // write: address and data offered together, bready held until the answer
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    @(posedge clk_in);
    {awa, wd, awv, wv, bre} <= {a, d, 3'h7};
    hb = 1'b0;
    for (int n = 0; n < 99 && !hb; n++)
    begin
      @(negedge clk_in);
      {ha, hw, hb} = {awv & awr, wv & wrdy, bre & bv};
      if (hb) chk("bresp", {30'h0, er}, {30'h0, br});
      @(posedge clk_in);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      if (hb) bre <= 1'b0;
    end
    if (!hb)
    begin
      fail_count++;
      conclude();
    end
  endtask
  // read and compare the masked word
  task automatic rdc(input logic [15:0] a, input logic [1:0] er, input logic [31:0] e, input logic [31:0] m,
    input string nm);
    logic ha, hb;
    logic [31:0] d;
    @(posedge clk_in);
    {ara, arv, rre} <= {a, 2'h3};
    hb = 1'b0;
    for (int n = 0; n < 99 && !hb; n++)
    begin
      @(negedge clk_in);
      {ha, hb, d} = {arv & arr, rre & rv, rdat};
      if (hb) chk("rresp", {30'h0, er}, {30'h0, rr});
      if (hb) chk(nm, e, d & m);
      @(posedge clk_in);
      if (ha) arv <= 1'b0;
      if (hb) rre <= 1'b0;
    end
    if (!hb)
    begin
      fail_count++;
      conclude();
    end
  endtask
  // pin clock pulse, after letting the pin synchronisers settle
  task automatic pulse;
    repeat (4) @(posedge clk_in);
    pclk <= 1'b1;
    repeat (6) @(posedge clk_in);
    pclk <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask
  function automatic logic [31:0] clamp(input logic [31:0] x);
    return (x < 4) ? 32'h4 : (x > 8) ? 32'h8 : x;
  endfunction
  function automatic logic [31:0] step(input logic t, input logic [31:0] r, input logic s);
    return {31'h0, t ? r[0] ^ s : s};
  endfunction
  // ****************
  // stimulus
  // ****************
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial
  begin
    {reset_in, pclk, awv, wv, bre, arv, rre, lp, awa, ara, wd} = {7'h40, 75'h0};
    {fail_count, comparisons} = 0;
    v = $urandom(32'hdd0c97c8);
    drv = 10'($urandom);
    ws = 4'hf;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    rdc(PRELOAD_OFS, RESP_OKAY, 32'h0, ONES_REG, "regs");
    rdc(COUNT_OFS, RESP_OKAY, 32'h8, ONES_CNT, "count");
    rdc(16'h2000, RESP_SLVERR, 32'h0, ONES_LO, "hole");
    wr(PINS_OFS, 32'h0, RESP_SLVERR);
    v = $urandom_range(15);
    wr(COUNT_OFS + 16'h4, v, RESP_OKAY);
    rdc(COUNT_OFS + 16'h4, RESP_OKAY, clamp(v), ONES_CNT, "count");
    v = $urandom;
    wr(PRELOAD_OFS, v, RESP_OKAY);
    rdc(PRELOAD_OFS, RESP_OKAY, v & ONES_REG, ONES_REG, "preload");
    // only the two low byte lanes may land; the top lane keeps its old bits
    ws <= 4'h3;
    wr(PRELOAD_OFS, ~v, RESP_OKAY);
    rdc(PRELOAD_OFS, RESP_OKAY, (~v & 32'h0000_ffff) | (v & 32'h000f_0000), ONES_REG, "lanes");
    ws <= 4'hf;
    // sum of reg 0 follows input 0, pin 0 enabled by input 1, pin clock
    wr(16'h0000, 32'h2, RESP_OKAY);
    wr(16'h0c80, 32'h4, RESP_OKAY);
    wr(CLKSEL_OFS, 32'h1, RESP_OKAY);
    wr(PRELOAD_OFS, 32'h0, RESP_OKAY);
    q = 0;
    for (i = 0; i < 5; i++)
    begin
      if (i == 2) wr(TTYPE_OFS, 32'h1, RESP_OKAY);
      lp <= {10'h1, 1'(5'b01101 >> i)};
      pulse();
      q = step(i >= 2, q, 1'(5'b01101 >> i));
      chk("pin0", q, {31'h0, pins[0]});
      chk("oe0", 32'h1, {31'h0, poe[0]});
    end
    lp <= 11'h0;
    repeat (6) @(posedge clk_in);
    chk("free pin", {31'h0, drv[0]}, {31'h0, pins[0]});
    rdc(PINS_OFS, RESP_OKAY, {10'h0, drv, 12'h0}, ONES_LO, "pins");
    wr(16'h0d20, 32'h8, RESP_OKAY);
    // preset needs the register clock raised while it is true
    lp <= 11'h4;
    pulse();
    rdc(PRELOAD_OFS, RESP_OKAY, 32'h1, 32'h1, "preset");
    wr(16'h0b40, 32'h8, RESP_OKAY);
    // clock rise with preset and reset term both true
    pulse();
    rdc(PRELOAD_OFS, RESP_OKAY, 32'h0, 32'h1, "clear");
    // protection goes on only once all checks of the pattern are done
    wr(SECURE_OFS, 32'h1, RESP_OKAY);
    rdc(TTYPE_OFS, RESP_OKAY, ONES_REG, ONES_LO, "secure");
    rdc(16'h0000, RESP_OKAY, ONES_LO, ONES_LO, "secure term");
    conclude();
  end
endmodule
